// ===== rtl/dlc_host.sv
// Host controller driving up to four dual latch converters over shared pins.
// Assumes the converters latch on their level strobes and need no clock.
// Operation
// - Double buffering uses a chip-selected load then a separate transfer write.
// - All converters share transfer select; each has own chip select.
// - Stand-alone double: selects low, enable high, pulse load strobe.
// - Single buffering should capture in the input latch.
// - Stand-alone single: select, transfer pins low, strobe load per update.
// - Enable tied high in simple use, or low only to freeze the input latches.
`timescale 1ns/1ps
module dlc_host
    import dlc_pkg::*;
(
    // Clock and control
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    // Configuration, static during a write, changed only while idle
    input wire dlc_pkg::dlc_mode_t mode,
    // Requests
    input wire dlc_pkg::dlc_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output logic done,
    // Converter pins
    output dlc_pkg::dlc_pins_t pins
);
    import dlc_pkg::*;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_SETUP = 3'h1,
        ST_STROBE = 3'h2,
        ST_HOLD = 3'h3,
        ST_XSETUP = 3'h4,
        ST_XSTROBE = 3'h5,
        ST_XHOLD = 3'h6
    } dlc_state_t;

    dlc_state_t state_r;
    dlc_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    dlc_req_t req_r;
    dlc_pins_t pins_r;
    dlc_pins_t pins_nxt;
    logic ready_r;
    logic done_r;
    logic done_nxt;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic take = req_valid && ready_r;
    wire logic cnt_zero = (cnt_r == '0);
    wire logic flow = (mode == DLC_MODE_FLOW);
    wire logic single = (mode == DLC_MODE_SINGLE);
    wire logic freeze = (mode == DLC_MODE_FREEZE);
    logic [NCONV-1:0] sel_onehot;
    // Per-converter chip select, one-hot from the target
    generate
        for (genvar i = 0; i < NCONV; i++)
        begin : g_sel
            assign sel_onehot[i] = (req_r.target == 2'(i));
        end
    endgenerate
    // Shared transfer select, own chip selects
    wire logic [NCONV-1:0] cs_active_n = ~sel_onehot;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_zero ? cnt_r : cnt_r - 1'b1;
        pins_nxt = pins_r;
        done_nxt = 1'b0;
        // Enable tied high, low only to freeze latches
        pins_nxt.input_latch_enable = !freeze;
        unique case (state_r)
            ST_IDLE:
            begin
                if (flow)
                begin
                    // Selects and strobes low, enable high, data streams through
                    pins_nxt.chip_select_n = '0;
                    pins_nxt.load_strobe_n = 1'b0;
                    pins_nxt.transfer_strobe_n = 1'b0;
                    pins_nxt.transfer_select_n = 1'b0;
                    if (req_valid)
                        pins_nxt.code_in = req.code;
                end
                else
                begin
                    pins_nxt.chip_select_n = CS_RST;
                    pins_nxt.load_strobe_n = STROBE_RST;
                    pins_nxt.transfer_strobe_n = !single;
                    pins_nxt.transfer_select_n = !single;
                end
                if (take && !flow)
                begin
                    pins_nxt.code_in = req.code;
                    cnt_nxt = CNT_W'(SETUP_CYC - 1);
                    state_nxt = (req.load || single) ? ST_SETUP : ST_XSETUP;
                end
                done_nxt = take && flow;
            end
            ST_SETUP:
            begin
                // Chip select asserted ahead of the strobe
                pins_nxt.chip_select_n = cs_active_n;
                if (cnt_zero)
                begin
                    // Load strobe low opens the input latch
                    pins_nxt.load_strobe_n = 1'b0;
                    cnt_nxt = CNT_W'(STROBE_CYC - 1);
                    state_nxt = ST_STROBE;
                end
            end
            ST_STROBE:
            begin
                if (cnt_zero)
                begin
                    // Rising edge captures, data still held
                    pins_nxt.load_strobe_n = 1'b1;
                    cnt_nxt = CNT_W'(HOLD_CYC - 1);
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (cnt_zero)
                begin
                    pins_nxt.chip_select_n = CS_RST;
                    cnt_nxt = CNT_W'(SETUP_CYC - 1);
                    // Single mode needs one strobe per update
                    state_nxt = (req_r.transfer && !single) ? ST_XSETUP : ST_IDLE;
                    done_nxt = !(req_r.transfer && !single);
                end
            end
            ST_XSETUP:
            begin
                // Select low first, strobe opens the latch
                pins_nxt.transfer_select_n = 1'b0;
                if (cnt_zero)
                begin
                    // Copy input latches of all converters
                    pins_nxt.transfer_strobe_n = 1'b0;
                    cnt_nxt = CNT_W'(STROBE_CYC - 1);
                    state_nxt = ST_XSTROBE;
                end
            end
            ST_XSTROBE:
            begin
                if (cnt_zero)
                begin
                    pins_nxt.transfer_strobe_n = 1'b1;
                    cnt_nxt = CNT_W'(HOLD_CYC - 1);
                    state_nxt = ST_XHOLD;
                end
            end
            ST_XHOLD:
            begin
                if (cnt_zero)
                begin
                    pins_nxt.transfer_select_n = 1'b1;
                    state_nxt = ST_IDLE;
                    done_nxt = 1'b1;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            req_r <= '0;
            ready_r <= 1'b0;
            done_r <= 1'b0;
            pins_r <= {CS_RST, 1'b1, STROBE_RST, STROBE_RST, 1'b1, 8'h00};
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pins_r <= pins_nxt;
            done_r <= done_nxt;
            ready_r <= (state_nxt == ST_IDLE);
            if (take)
                req_r <= req;
        end
    end

    // Code bits pass straight, write only
    assign pins = pins_r;
    assign req_ready = ready_r;
    assign done = done_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence load_fall_s;
        $fell(pins_r.load_strobe_n) && !flow;
    endsequence

    strobe_width_a: assert property (load_fall_s |-> !pins_r.load_strobe_n [*8])
        else $error("load strobe too short");
    load_qual_a: assert property ((!pins_r.load_strobe_n && !flow) |->
        (pins_r.chip_select_n != CS_RST))
        else $error("load strobe without chip select");
    transfer_select_n_qual_a: assert property ($fell(pins_r.transfer_strobe_n) && !flow && !single |->
        !pins_r.transfer_select_n)
        else $error("transfer strobe without select");
    transfer_select_n_close_a: assert property ($rose(pins_r.transfer_strobe_n) && state_r == ST_XHOLD |=>
        !pins_r.transfer_select_n)
        else $error("select released before strobe");
    freeze_a: assert property (clk_en && $past(freeze) && $past(clk_en) && !$past(srst) |->
        !pins_r.input_latch_enable)
        else $error("enable high while frozen");
    hold_data_a: assert property ($rose(pins_r.load_strobe_n) |->
        $stable(pins_r.code_in))
        else $error("data moved at strobe rise");
    cs_held_a: assert property ($rose(pins_r.load_strobe_n) && state_r == ST_HOLD |->
        pins_r.chip_select_n != CS_RST)
        else $error("chip select dropped early");
    single_open_a: assert property (state_r == ST_IDLE && single && $past(single) && clk_en
        && $past(clk_en) |-> !pins_r.transfer_strobe_n && !pins_r.transfer_select_n)
        else $error("converter latch not open in single mode");

endmodule // dlc_host

// ===== common/dlc_pkg.sv
// Package for the dual latch converter host controller.
// Assumes a 200 MHz clock and a converter driven only by its control pins.
package dlc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    // Least strobe low width, in ns
    localparam int STROBE_MIN_NS = 900;
    // Least data hold after strobe rise, in ns
    localparam int HOLD_MIN_NS = 50;
    // Least control and data setup before strobe, in ns
    localparam int SETUP_MIN_NS = 320;
    localparam int STROBE_CYC = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int HOLD_CYC = (HOLD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETUP_CYC = (SETUP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 8;
    localparam int CODE_W = 8;
    localparam int NCONV = 4;

    // ------------------------------------------------------------
    // Reset values of the pins
    // ------------------------------------------------------------
    localparam logic [NCONV-1:0] CS_RST = 4'hf;
    localparam logic STROBE_RST = 1'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        DLC_MODE_DOUBLE = 2'h0,
        DLC_MODE_SINGLE = 2'h1,
        DLC_MODE_FLOW = 2'h2,
        DLC_MODE_FREEZE = 2'h3
    } dlc_mode_t;

    // Request: load one converter and/or transfer all
    typedef struct packed
    {
        logic [1:0] target;
        logic load;
        logic transfer;
        logic [CODE_W-1:0] code;
    } dlc_req_t;

    // Pins towards the converters
    typedef struct packed
    {
        logic [NCONV-1:0] chip_select_n;
        logic input_latch_enable;
        logic load_strobe_n;
        logic transfer_strobe_n;
        logic transfer_select_n;
        logic [CODE_W-1:0] code_in;
    } dlc_pins_t;

endpackage

// ===== testbench/dlc_conv_model.sv
// Behavioural model of one dual latch converter, digital side only.
// Assumes level strobes from a host; no clock, result is the latched code.
`timescale 1ns/1ps
module dlc_conv_model
    import dlc_pkg::*;
(
    // Control pins
    input wire logic chip_select_n,
    input wire logic input_latch_enable,
    input wire logic load_strobe_n,
    input wire logic transfer_strobe_n,
    input wire logic transfer_select_n,
    // Data and result
    input wire logic [dlc_pkg::CODE_W-1:0] code_in,
    output logic [dlc_pkg::CODE_W-1:0] code_out
);
    logic [CODE_W-1:0] input_r;
    logic [CODE_W-1:0] conv_r;
    wire load_open = input_latch_enable && !chip_select_n && !load_strobe_n;
    wire transfer_select_n_open = !transfer_strobe_n && !transfer_select_n;
    // input latch, first of the series pair
    always_latch
    begin
        if (load_open)
            input_r <= code_in;
    end
    // Converter latch copies whatever the input latch holds
    always_latch
    begin
        if (transfer_select_n_open)
            conv_r <= input_r;
    end
    assign code_out = conv_r;
endmodule // dlc_conv_model

// ===== testbench/tb_dlc_host.sv
// Testbench for the host controller driving four converter models.
// Assumes a 5 ns clock; inputs change on the falling edge.
`timescale 1ns/1ps
module tb_dlc_host;
    import dlc_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    dlc_mode_t mode = DLC_MODE_DOUBLE;
    dlc_req_t req = '0;
    logic req_valid = 1'b0;
    logic clk_en = 1'b1;
    logic req_ready;
    logic done;
    dlc_pins_t pins;
    logic [CODE_W-1:0] dac [NCONV];
    int errors = 0;
    int tests_run = 0;

    always #2.5 clock = ~clock;

    dlc_host u_dut (.clock(clock), .srst(srst), .clk_en(clk_en), .mode(mode), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .done(done), .pins(pins));

    for (genvar i = 0; i < NCONV; i++)
    begin : g_conv
        dlc_conv_model u_conv (.chip_select_n(pins.chip_select_n[i]),
            .input_latch_enable(pins.input_latch_enable), .load_strobe_n(pins.load_strobe_n),
            .transfer_strobe_n(pins.transfer_strobe_n),
            .transfer_select_n(pins.transfer_select_n), .code_in(pins.code_in),
            .code_out(dac[i]));
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait on ready or done; running out ends the run
    task automatic wait_high(input bit on_done);
        int n;
        n = 0;
        while ((on_done ? done : req_ready) !== 1'b1 && n < 2000)
        begin
            @(negedge clock);
            n++;
        end
        if (n >= 2000)
        begin
            errors++;
            $display("Error at %0t ns: got %h expected %h", $time,
                (on_done ? done : req_ready), 1'b1);
            tally_and_finish();
        end
    endtask

    task automatic send(input logic [1:0] tgt, input logic ld, input logic xf,
        input logic [7:0] code);
        wait_high(1'b0);
        req = '{target: tgt, load: ld, transfer: xf, code: code};
        req_valid = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
        wait_high(1'b1);
        @(negedge clock);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_double();
        for (int i = 0; i < NCONV; i++)
        begin
            send(i[1:0], 1'b1, 1'b1, 8'h81 + 8'(i * 8'h11));
            check(dac[i], 8'h81 + 8'(i * 8'h11));
            check({4'h0, pins.chip_select_n}, 8'h0f);
        end
        $display("double buffered updates done");
    endtask

    task automatic t_shared();
        send(2'h1, 1'b1, 1'b0, 8'ha5);
        send(2'h3, 1'b1, 1'b0, 8'h3c);
        check(dac[1], 8'h92);
        check(dac[3], 8'hb4);
        send(2'h0, 1'b0, 1'b1, 8'h00);
        check(dac[0], 8'h81);
        check(dac[1], 8'ha5);
        check(dac[2], 8'ha3);
        check(dac[3], 8'h3c);
        $display("shared transfer done");
    endtask

    task automatic t_freeze();
        wait_high(1'b0);
        mode = DLC_MODE_FREEZE;
        send(2'h2, 1'b1, 1'b0, 8'hee);
        check({7'h0, pins.input_latch_enable}, 8'h00);
        mode = DLC_MODE_DOUBLE;
        send(2'h0, 1'b0, 1'b1, 8'h00);
        check(dac[2], 8'ha3);
        $display("freeze done");
    endtask

    // Clock enable low mid-write must hold the load strobe and chip selects
    task automatic t_pause();
        wait_high(1'b0);
        req = '{target: 2'h2, load: 1'b1, transfer: 1'b1, code: 8'h77};
        req_valid = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
        @(negedge clock);
        clk_en = 1'b0;
        repeat (400) @(negedge clock);
        check({pins.load_strobe_n, 3'h0, pins.chip_select_n}, 8'h8b);
        clk_en = 1'b1;
        wait_high(1'b1);
        @(negedge clock);
        check(dac[2], 8'h77);
        $display("clock enable pause done");
    endtask

    task automatic t_single();
        wait_high(1'b0);
        mode = DLC_MODE_SINGLE;
        send(2'h0, 1'b1, 1'b0, 8'h5a);
        check(dac[0], 8'h5a);
        check(dac[1], 8'ha5);
        check({7'h0, pins.transfer_strobe_n | pins.transfer_select_n}, 8'h00);
        $display("single buffered done");
    endtask

    task automatic t_flow();
        wait_high(1'b0);
        mode = DLC_MODE_FLOW;
        repeat (2) @(negedge clock);
        req = '{target: 2'h0, load: 1'b1, transfer: 1'b0, code: 8'hc3};
        req_valid = 1'b1;
        repeat (4) @(negedge clock);
        for (int i = 0; i < NCONV; i++)
            check(dac[i], 8'hc3);
        check({7'h0, done}, 8'h01);
        req_valid = 1'b0;
        repeat (4) @(negedge clock);
        wait_high(1'b0);
        mode = DLC_MODE_DOUBLE;
        $display("flow-through done");
    endtask

    initial
    begin
        repeat (12) @(negedge clock);
        srst = 1'b0;
        repeat (2) @(negedge clock);
        t_double();
        t_shared();
        t_freeze();
        t_pause();
        t_single();
        t_flow();
        tally_and_finish();
    end
endmodule // tb_dlc_host
